// ===== design/emc_pkg.sv
// constants shared by the event mission control block
// assumes one 50 mhz core clock and an external log memory written by word
package emc_pkg;

  // ****************
  // register map
  // ****************
  localparam logic [7:0] EMC_ADDR_CTRL   = 8'h0e;
  localparam logic [7:0] EMC_ADDR_STATUS = 8'h0f;
  localparam logic [7:0] EMC_CTRL_RESET  = 8'h00;

  // control field positions
  localparam int EMC_CB_ARM    = 7;
  localparam int EMC_CB_WIPEEN = 6;
  localparam int EMC_CB_ISELHI = 5;
  localparam int EMC_CB_ISELLO = 4;
  localparam int EMC_CB_WRAP   = 3;
  localparam int EMC_CB_ESELHI = 2;
  localparam int EMC_CB_ESELLO = 1;
  localparam int EMC_CB_OSC    = 0;

  // status field positions
  localparam int EMC_SB_WIPED = 6;
  localparam int EMC_SB_RUN   = 5;
  localparam int EMC_SB_CMD   = 4;
  localparam int EMC_SB_ROLL  = 2;
  localparam int EMC_SB_ALARM = 0;

  // ****************
  // field encodings
  // ****************
  localparam logic [1:0] EMC_ISEL_ALARM = 2'h0;
  localparam logic [1:0] EMC_ISEL_SEC   = 2'h1;
  localparam logic [1:0] EMC_ISEL_MIN   = 2'h2;
  localparam logic [1:0] EMC_ISEL_HOUR  = 2'h3;
  localparam logic [1:0] EMC_ESEL_NONE  = 2'h0;
  localparam logic [1:0] EMC_ESEL_FALL  = 2'h1;
  localparam logic [1:0] EMC_ESEL_RISE  = 2'h2;
  localparam logic [1:0] EMC_ESEL_BOTH  = 2'h3;

  // ****************
  // log geometry and counts
  // ****************
  localparam int          EMC_PTR_W    = 11;
  localparam int          EMC_STAMP_W  = 56;
  localparam int          EMC_EVCNT_W  = 24;
  localparam logic [10:0] EMC_PTR_ZERO = 11'h000;
  localparam logic [10:0] EMC_PTR_STEP = 11'h002;
  localparam logic [10:0] EMC_PTR_LAST = 11'h7fe;
  localparam logic [15:0] EMC_ETC_MAX  = 16'hffff;
  localparam logic [15:0] EMC_ETC_ZERO = 16'h0000;
  localparam logic [23:0] EMC_EVCNT_ONE = 24'h000001;

  // ****************
  // timing
  // ****************
  localparam int EMC_CLK_MHZ = 50;

  typedef enum logic [1:0] {
    EMC_WIPE_IDLE,
    EMC_WIPE_RUN,
    EMC_WIPE_DONE
  } emc_wipe_t;

endpackage : emc_pkg

// ===== design/emc_edge_detect.sv
// event input conditioning: three stage synchroniser and edge selection
// assumes the event pin is asynchronous to clock
`timescale 1ns/1ps
module emc_edge_detect
  import emc_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // raw event pin and selection
  input  wire logic       eventPin,
  input  wire logic [1:0] edgeSel,
  // one cycle event pulse
  output logic            eventPulse
);

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic level_r;

  // ****************
  // synchroniser, change accepted when stages two and three agree
  // ****************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      sync1_r <= eventPin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        level_r <= sync3_r;
      end
    end
  end

  // edge select; code zero never fires
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      eventPulse <= 1'b0;
    end else begin
      case (edgeSel)
        EMC_ESEL_FALL: eventPulse <= level_r & ~sync3_r & ~sync2_r;
        EMC_ESEL_RISE: eventPulse <= ~level_r & sync3_r & sync2_r;
        EMC_ESEL_BOTH: eventPulse <= (level_r != sync3_r) && (sync2_r == sync3_r);
        default:       eventPulse <= 1'b0;
      endcase
    end
  end

endmodule // emc_edge_detect

// ===== design/emc_mission_control.sv
// mission control of the event recorder: control and status bits, mission start
// and stop, two step log wipe, interval counting and log writes
// assumes register writes arrive already decoded from the serial slave, the
// calendar gives one cycle increment pulses and a live stamp, and the log
// memory is outside and takes one 16 bit word per write strobe
`timescale 1ns/1ps

// Summary of operation
// - arming is ignored unless the log has been wiped
// - armed device starts the mission on first event, stamping and counting it
// - writing run while unarmed arms, stamps and starts the mission at once
// - any mission stop clears the arm bit by itself
// - wipe enable then wipe command zeroes log, event count and start stamp
// - a finished wipe clears wipe enable and sets the wiped flag
// - any other write after wipe enable drops it and leaves data alone
// - interval select picks seconds, minutes, hours, or alarm with no logging
// - a tick with the counter at fffe logs ffff and advances pointer while the log has room, wraps to zero, continues
// - a counter wrap does not change the event count
// - each later event logs the counter while the log has room, and restarts it
// - counter advances only on the selected calendar increment
// - an event before any advance logs zero and restarts
// - no start with interval select zero; then alarm drives event pin low
// - with wrap, event after 1024 logs restamps and fills rollover stamp, later events overwrite
// - without wrap, a full log stops writes but events still count
// - edge select chooses falling, rising or both edges
// - edge select zero detects nothing and blocks mission start
// - oscillator off refuses mission start and wipe
// - main supply above backup forces the oscillator on
// - any host write during a mission stops it, clearing run and arm
// - pointer holds the next low byte address, the oldest entry after wrap
module emc_mission_control
  import emc_pkg::*;
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // decoded register writes from the serial slave
  input  wire logic                   regWrite,
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  // calendar side
  input  wire logic                   secTick,
  input  wire logic                   minTick,
  input  wire logic                   hourTick,
  input  wire logic [EMC_STAMP_W-1:0] calendarNow,
  input  wire logic                   alarmFlag,
  input  wire logic                   mainAboveBackup,
  // event pin, open drain
  input  wire logic                   eventPinIn,
  output logic                        eventPinOut,
  output logic                        eventPinOe,
  // register read images
  output logic [7:0]                  ctrlRead,
  output logic [7:0]                  statusRead,
  // mission records
  output logic [EMC_STAMP_W-1:0]      startStamp,
  output logic [15:0]                 rolloverStamp,
  output logic [EMC_EVCNT_W-1:0]      eventCount,
  output logic [EMC_PTR_W-1:0]        addrPointer,
  // log memory write port
  output logic                        logWrite,
  output logic [EMC_PTR_W-1:0]        logAddr,
  output logic [15:0]                 logData,
  // oscillator gate
  output logic                        oscActive
);

  // control fields
  logic       missionArm_r;
  logic       wipeEnable_r;
  logic [1:0] intervalSel_r;
  logic       wrapEnable_r;
  logic [1:0] edgeSel_r;
  logic       oscRun_r;
  // status and mission state
  logic       logWiped_r;
  logic       missionRunning_r;
  logic       rollFlag_r;
  logic       logFull_r;
  logic       advanced_r;
  logic [15:0] intervalCounter_r;
  emc_wipe_t  wipeState_r;
  logic [EMC_PTR_W-1:0] wipeAddr_r;

  logic eventPulse;
  logic oscOn;
  logic settingsOk;
  logic ctrlWr;
  logic statWr;
  logic hostStart;
  logic eventStart;
  logic missionStop;
  logic wipeStart;
  logic wipeLast;
  logic selTick;
  logic liveEvent;
  logic etcAtMax;
  logic rollNow;
  logic logSlot;
  logic [EMC_PTR_W-1:0] ptrNext;

  // ****************
  // event input
  // ****************
  emc_edge_detect u_edge (
    .clock      (clock),
    .rstn       (rstn),
    .eventPin   (eventPinIn),
    .edgeSel    (edgeSel_r),
    .eventPulse (eventPulse)
  );

  // ****************
  // decode and qualifying terms
  // ****************
  assign oscOn      = oscRun_r | mainAboveBackup;
  // a mission needs logging on, a legal edge and a running oscillator
  assign settingsOk = (intervalSel_r != EMC_ISEL_ALARM)
                    & (edgeSel_r != EMC_ESEL_NONE)
                    & oscOn;
  assign ctrlWr     = regWrite & (regAddr == EMC_ADDR_CTRL);
  assign statWr     = regWrite & (regAddr == EMC_ADDR_STATUS);
  assign hostStart  = statWr & regWdata[EMC_SB_RUN] & ~missionArm_r & ~missionRunning_r
                    & logWiped_r & settingsOk & (wipeState_r == EMC_WIPE_IDLE);
  assign eventStart = eventPulse & missionArm_r & ~missionRunning_r & settingsOk;
  // every write during a mission ends it, the stop write included
  assign missionStop = missionRunning_r & regWrite;
  assign wipeStart  = statWr & regWdata[EMC_SB_CMD] & wipeEnable_r & oscOn
                    & (wipeState_r == EMC_WIPE_IDLE);
  assign wipeLast   = (wipeAddr_r == EMC_PTR_LAST);

  // selected calendar increment, nothing while in alarm mode
  always_comb begin
    case (intervalSel_r)
      EMC_ISEL_SEC:  selTick = secTick;
      EMC_ISEL_MIN:  selTick = minTick;
      EMC_ISEL_HOUR: selTick = hourTick;
      default:       selTick = 1'b0;
    endcase
  end

  // an event inside a mission; the stopping write wins over it
  assign liveEvent = eventPulse & missionRunning_r & ~missionStop;
  assign etcAtMax  = (intervalCounter_r == EMC_ETC_MAX);
  // full log with wrap on: next event restamps instead of logging
  assign rollNow   = liveEvent & logFull_r & wrapEnable_r;
  assign logSlot   = ~logFull_r;
  assign ptrNext   = addrPointer + EMC_PTR_STEP;

  // ****************
  // control register
  // ****************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intervalSel_r <= EMC_CTRL_RESET[EMC_CB_ISELHI:EMC_CB_ISELLO];
      wrapEnable_r  <= EMC_CTRL_RESET[EMC_CB_WRAP];
      edgeSel_r     <= EMC_CTRL_RESET[EMC_CB_ESELHI:EMC_CB_ESELLO];
      oscRun_r      <= EMC_CTRL_RESET[EMC_CB_OSC];
    end else if (ctrlWr) begin
      intervalSel_r <= regWdata[EMC_CB_ISELHI:EMC_CB_ISELLO];
      wrapEnable_r  <= regWdata[EMC_CB_WRAP];
      edgeSel_r     <= regWdata[EMC_CB_ESELHI:EMC_CB_ESELLO];
      oscRun_r      <= regWdata[EMC_CB_OSC];
    end
  end

  // arm bit: only after a wipe and with legal settings, dropped on any stop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      missionArm_r <= EMC_CTRL_RESET[EMC_CB_ARM];
    end else if (missionStop || wipeStart) begin
      missionArm_r <= 1'b0;
    end else if (hostStart) begin
      missionArm_r <= 1'b1;
    end else if (ctrlWr) begin
      missionArm_r <= regWdata[EMC_CB_ARM] & logWiped_r & settingsOk
                    & ~missionRunning_r;
    end
  end

  // wipe enable: one shot, any write but the wipe command cancels it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wipeEnable_r <= EMC_CTRL_RESET[EMC_CB_WIPEEN];
    end else if (wipeState_r == EMC_WIPE_DONE) begin
      wipeEnable_r <= 1'b0;
    end else if (regWrite && wipeEnable_r && !wipeStart) begin
      wipeEnable_r <= 1'b0;
    end else if (ctrlWr && !wipeEnable_r) begin
      wipeEnable_r <= regWdata[EMC_CB_WIPEEN];
    end
  end

  // ****************
  // wipe sequencer, one zero word per cycle over the whole log
  // ****************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wipeState_r <= EMC_WIPE_IDLE;
      wipeAddr_r  <= EMC_PTR_ZERO;
    end else begin
      case (wipeState_r)
        EMC_WIPE_IDLE: begin
          wipeAddr_r <= EMC_PTR_ZERO;
          if (wipeStart) begin
            wipeState_r <= EMC_WIPE_RUN;
          end
        end
        EMC_WIPE_RUN: begin
          wipeAddr_r <= wipeAddr_r + EMC_PTR_STEP;
          if (wipeLast) begin
            wipeState_r <= EMC_WIPE_DONE;
          end
        end
        EMC_WIPE_DONE: wipeState_r <= EMC_WIPE_IDLE;
        default:       wipeState_r <= EMC_WIPE_IDLE;
      endcase
    end
  end

  // ****************
  // mission state and flags
  // ****************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      missionRunning_r <= 1'b0;
      logWiped_r       <= 1'b0;
      rollFlag_r       <= 1'b0;
    end else begin
      if (missionStop || wipeStart) begin
        missionRunning_r <= 1'b0;
      end else if (hostStart || eventStart) begin
        missionRunning_r <= 1'b1;
      end
      // wiped flag is set only by a finished wipe, lost when a mission begins
      if (wipeState_r == EMC_WIPE_DONE) begin
        logWiped_r <= 1'b1;
      end else if (hostStart || eventStart || wipeStart) begin
        logWiped_r <= 1'b0;
      end
      if (wipeState_r == EMC_WIPE_DONE) begin
        rollFlag_r <= 1'b0;
      end else if (liveEvent && logFull_r) begin
        rollFlag_r <= 1'b1;
      end
    end
  end

  // start and rollover stamps
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      startStamp    <= '0;
      rolloverStamp <= EMC_ETC_ZERO;
    end else if (wipeState_r == EMC_WIPE_RUN) begin
      startStamp    <= '0;
      rolloverStamp <= EMC_ETC_ZERO;
    end else if (hostStart || eventStart) begin
      startStamp    <= calendarNow;
      rolloverStamp <= EMC_ETC_ZERO;
    end else if (rollNow) begin
      startStamp    <= calendarNow;
      rolloverStamp <= advanced_r ? intervalCounter_r : EMC_ETC_ZERO;
    end
  end

  // event counter: starts, later events; never a counter wrap
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      eventCount <= '0;
    end else if (wipeState_r == EMC_WIPE_RUN) begin
      eventCount <= '0;
    end else if (hostStart || eventStart || liveEvent) begin
      eventCount <= eventCount + EMC_EVCNT_ONE;
    end
  end

  // ****************
  // interval counter; event beats increment in the same cycle
  // ****************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intervalCounter_r <= EMC_ETC_ZERO;
      advanced_r        <= 1'b0;
    end else if (wipeState_r == EMC_WIPE_RUN || hostStart || eventStart || liveEvent) begin
      intervalCounter_r <= EMC_ETC_ZERO;
      advanced_r        <= 1'b0;
    end else if (missionRunning_r && selTick) begin
      advanced_r <= 1'b1;
      if (intervalCounter_r == EMC_ETC_MAX - 16'h0001) begin
        intervalCounter_r <= EMC_ETC_ZERO;
      end else begin
        intervalCounter_r <= intervalCounter_r + 16'h0001;
      end
    end
  end

  // ****************
  // log writes and pointer
  // ****************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      logWrite    <= 1'b0;
      logAddr     <= EMC_PTR_ZERO;
      logData     <= EMC_ETC_ZERO;
      addrPointer <= EMC_PTR_ZERO;
      logFull_r   <= 1'b0;
    end else begin
      logWrite <= 1'b0;
      if (wipeState_r == EMC_WIPE_RUN) begin
        logWrite    <= 1'b1;
        logAddr     <= wipeAddr_r;
        logData     <= EMC_ETC_ZERO;
        addrPointer <= EMC_PTR_ZERO;
        logFull_r   <= 1'b0;
      end else if (rollNow) begin
        logFull_r <= 1'b0;
      end else if (liveEvent && logSlot) begin
        logWrite    <= 1'b1;
        logAddr     <= addrPointer;
        // no advance yet means the counter still reads zero
        logData     <= advanced_r ? intervalCounter_r : EMC_ETC_ZERO;
        addrPointer <= ptrNext;
        logFull_r   <= (addrPointer == EMC_PTR_LAST);
      end else if (missionRunning_r && selTick && !liveEvent && logSlot
                   && intervalCounter_r == EMC_ETC_MAX - 16'h0001) begin
        logWrite    <= 1'b1;
        logAddr     <= addrPointer;
        logData     <= EMC_ETC_MAX;
        addrPointer <= ptrNext;
        logFull_r   <= (addrPointer == EMC_PTR_LAST);
      end
    end
  end

  // ****************
  // pin, oscillator and read images
  // ****************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      eventPinOut <= 1'b0;
      eventPinOe  <= 1'b0;
      oscActive   <= 1'b0;
      ctrlRead    <= EMC_CTRL_RESET;
      statusRead  <= 8'h00;
    end else begin
      eventPinOut <= 1'b0;
      // open drain: only ever pull low, and only in alarm mode
      eventPinOe  <= alarmFlag & (intervalSel_r == EMC_ISEL_ALARM);
      oscActive   <= oscOn;
      ctrlRead    <= {missionArm_r, wipeEnable_r, intervalSel_r, wrapEnable_r,
                      edgeSel_r, oscRun_r};
      statusRead  <= 8'h00;
      statusRead[EMC_SB_WIPED] <= logWiped_r;
      statusRead[EMC_SB_RUN]   <= missionRunning_r;
      statusRead[EMC_SB_CMD]   <= (wipeState_r != EMC_WIPE_IDLE);
      statusRead[EMC_SB_ROLL]  <= rollFlag_r;
      statusRead[EMC_SB_ALARM] <= alarmFlag;
    end
  end

endmodule // emc_mission_control

// ===== bench/emc_host_model.sv
// host side model: issues decoded byte writes and the two step log wipe
// assumes the bench calls its tasks after a clock edge has settled
`timescale 1ns/1ps
module emc_host_model
  import emc_pkg::*;
(
  // clock and read image
  input  wire logic       clock,
  input  wire logic [7:0] statusRead,
  // decoded write strobe
  output logic            regWrite,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWdata
);
  // idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end

  // one cycle strobe; released address and data show no stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask

  // enable then command, then keep off the bus until the wipe is over
  task automatic wipe(input logic [7:0] c, output logic ok);
    int i;
    wr(EMC_ADDR_CTRL, c | 8'h40);
    wr(EMC_ADDR_STATUS, 8'h10);
    repeat (8) @(posedge clock);
    ok = 1'b0;
    for (i = 0; i < 2000 && !ok; i++) begin
      @(posedge clock);
      ok = statusRead[6] && !statusRead[4];
    end
  endtask
endmodule // emc_host_model

// ===== bench/emc_mission_control_sva.sv
// port assertions for the mission control block
// assumes read images lag the internal state by one edge
`timescale 1ns/1ps
module emc_mission_control_sva
  import emc_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // host and calendar side
  input wire logic        regWrite,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        alarmFlag,
  input wire logic        mainAboveBackup,
  // outputs watched
  input wire logic        eventPinOe,
  input wire logic [7:0]  ctrlRead,
  input wire logic [7:0]  statusRead,
  input wire logic [10:0] addrPointer,
  input wire logic        logWrite,
  input wire logic [10:0] logAddr,
  input wire logic [15:0] logData,
  input wire logic        oscActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // ****************
  // properties
  // ****************
  property p_arm_wiped;
    $rose(ctrlRead[7]) |-> $past(statusRead[6]);
  endproperty
  a_arm_wiped: assert property (p_arm_wiped) else $error("arm set on unwiped log");
  property p_stop_arm;
    $fell(statusRead[5]) |-> !ctrlRead[7];
  endproperty
  a_stop_arm: assert property (p_stop_arm) else $error("arm kept after stop");
  property p_wipe_zero;
    logWrite && !statusRead[5] |-> logData == 16'h0000;
  endproperty
  a_wipe_zero: assert property (p_wipe_zero) else $error("nonzero wipe word");
  property p_wipe_done;
    $fell(statusRead[4]) |-> ##[0:2] (statusRead[6] && !ctrlRead[6]);
  endproperty
  a_wipe_done: assert property (p_wipe_done) else $error("wipe end flags wrong");
  property p_wipe_cancel;
    regWrite && ctrlRead[6] && !(regAddr == EMC_ADDR_STATUS && regWdata[4]) |-> ##2 !ctrlRead[6];
  endproperty
  a_wipe_cancel: assert property (p_wipe_cancel) else $error("wipe enable kept");
  property p_alarm;
    $stable({alarmFlag, ctrlRead[5:4]}) [*3]
      |-> eventPinOe == (alarmFlag && ctrlRead[5:4] == EMC_ISEL_ALARM);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pin drive wrong");
  property p_osc;
    $stable({mainAboveBackup, ctrlRead[0]}) [*3] |-> oscActive == (mainAboveBackup || ctrlRead[0]);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator gate wrong");
  property p_log_ptr;
    logWrite && statusRead[5] |-> ##[0:1] addrPointer == logAddr + EMC_PTR_STEP;
  endproperty
  a_log_ptr: assert property (p_log_ptr) else $error("pointer not past entry");

  // main scenarios reached
  c_wipe: cover property ($fell(statusRead[4]));
  c_ffff: cover property (logWrite && logData == 16'hffff);
  c_roll: cover property ($rose(statusRead[2]));
endmodule // emc_mission_control_sva

bind emc_mission_control emc_mission_control_sva u_sva (.clock, .rstn, .regWrite, .regAddr,
  .regWdata, .alarmFlag, .mainAboveBackup, .eventPinOe, .ctrlRead, .statusRead, .addrPointer,
  .logWrite, .logAddr, .logData, .oscActive);

// ===== bench/test_emc_mission_control.sv
// self-checking bench for the mission control block
// assumes host writes come from the host model, ticks and pin are driven here
`timescale 1ns/1ps
module test_emc_mission_control
  import emc_pkg::*;
;
  logic        clock, rstn, secTick, minTick, hourTick, alarmFlag, mainAboveBackup, eventPinIn;
  logic        regWrite, eventPinOut, eventPinOe, logWrite, oscActive, ok;
  logic [7:0]  regAddr, regWdata, ctrlRead, statusRead;
  logic [55:0] calendarNow, startStamp;
  logic [15:0] rolloverStamp, logData, lastData;
  logic [23:0] eventCount;
  logic [10:0] addrPointer, logAddr;
  int          nMismatch, numChecks, nLog;

  emc_mission_control dut (.clock, .rstn, .regWrite, .regAddr, .regWdata, .secTick, .minTick,
    .hourTick, .calendarNow, .alarmFlag, .mainAboveBackup, .eventPinIn, .eventPinOut, .eventPinOe,
    .ctrlRead, .statusRead, .startStamp, .rolloverStamp, .eventCount, .addrPointer, .logWrite,
    .logAddr, .logData, .oscActive);
  emc_host_model host (.clock, .statusRead, .regWrite, .regAddr, .regWdata);

  // ****************
  // clock, log monitor, helpers
  // ****************
  always #10 clock = ~clock;
  // sees the word before this edge's own updates land
  always @(posedge clock) begin
    if (logWrite) begin
      nLog++;
      lastData = logData;
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic closeOut();
    if (nMismatch == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // write, then allow state edge plus image edge
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    cyc(3);
  endtask
  // one pin change, long enough for sync, edge detect and log write
  task automatic pin(input logic v);
    @(posedge clock);
    eventPinIn <= v;
    cyc(8);
  endtask
  // hold {hour,min,sec} increments for n cycles
  task automatic tk(input logic [2:0] s, input int n);
    @(posedge clock);
    {hourTick, minTick, secTick} <= s;
    repeat (n) @(posedge clock);
    {hourTick, minTick, secTick} <= 3'b000;
    cyc(2);
  endtask
  task automatic wp(input logic [7:0] c);
    int n0;
    n0 = nLog;
    host.wipe(c, ok);
    cyc(2);
    if (ok !== 1'b1) begin
      nMismatch++;
      closeOut();
    end
    chk("ctrl", c, ctrlRead);
    chk("status", 8'h40, statusRead);
    chk("logs", n0 + 1024, nLog);
    chk("count", 0, eventCount);
    chk("stamp", 0, startStamp);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic s_guard();
    chk("status", 8'h00, statusRead);
    w(EMC_ADDR_CTRL, 8'h56);
    chk("osc", 1'b0, oscActive);
    @(posedge clock);
    mainAboveBackup <= 1'b1;
    cyc(3);
    chk("osc", 1'b1, oscActive);
    @(posedge clock);
    mainAboveBackup <= 1'b0;
    w(EMC_ADDR_STATUS, 8'h10);
    cyc(20);
    chk("logs", 0, nLog);
    w(EMC_ADDR_CTRL, 8'h96);
    chk("ctrl", 8'h16, ctrlRead);
    w(EMC_ADDR_CTRL, 8'h57);
    w(EMC_ADDR_CTRL, 8'h17);
    chk("ctrl", 8'h17, ctrlRead);
    chk("wiped", 1'b0, statusRead[6]);
  endtask
  task automatic s_edges();
    for (int e = 0; e < 3; e++) begin
      wp({5'h04, e[1:0], 1'b1});
      w(EMC_ADDR_CTRL, {5'h14, e[1:0], 1'b1});
      chk("arm", e != 0, ctrlRead[7]);
      pin(1'b1);
      chk("run", e == 2, statusRead[5]);
      pin(1'b0);
      // minutes mode: seconds and hours must not advance the counter
      if (e == 2) begin
        tk(3'b101, 2);
        tk(3'b010, 3);
        pin(1'b1);
        chk("log", 16'h0003, lastData);
        pin(1'b0);
      end
      chk("run", e != 0, statusRead[5]);
      chk("count", e, eventCount);
      chk("stamp", e != 0 ? calendarNow : 56'h0, startStamp);
      chk("roll stamp", 0, rolloverStamp);
      w(8'h20, 8'h00);
      chk("ctrl", {5'h04, e[1:0], 1'b1}, ctrlRead);
      chk("run", 1'b0, statusRead[5]);
    end
  endtask
  task automatic s_isel();
    wp(8'h07);
    w(EMC_ADDR_STATUS, 8'h20);
    chk("run", 1'b0, statusRead[5]);
    @(posedge clock);
    alarmFlag <= 1'b1;
    cyc(4);
    chk("alarm out", 1'b1, eventPinOe);
    chk("pin out", 1'b0, eventPinOut);
    @(posedge clock);
    alarmFlag <= 1'b0;
    cyc(4);
    chk("alarm out", 1'b0, eventPinOe);
  endtask
  task automatic s_log();
    int n0;
    wp(8'h17);
    w(EMC_ADDR_STATUS, 8'h20);
    chk("ctrl", 8'h97, ctrlRead);
    chk("stamp", calendarNow, startStamp);
    chk("count", 1, eventCount);
    tk(3'b110, 3);
    tk(3'b001, 2);
    pin(1'b1);
    chk("log", 16'h0002, lastData);
    pin(1'b0);
    chk("log", 16'h0000, lastData);
    tk(3'b001, 65535);
    chk("log", 16'hffff, lastData);
    chk("count", 3, eventCount);
    chk("ptr", 6, addrPointer);
    n0 = nLog;
    repeat (1021) pin(~eventPinIn);
    chk("ptr", 0, addrPointer);
    pin(~eventPinIn);
    chk("logs", n0 + 1021, nLog);
    chk("count", 1025, eventCount);
    chk("roll", 1'b1, statusRead[2]);
  endtask
  // wrap on, hours mode: fill the log, restamp, then overwrite from the bottom
  task automatic s_wrap();
    wp(8'h3f);
    w(EMC_ADDR_STATUS, 8'h20);
    repeat (1024) pin(~eventPinIn);
    chk("ptr", 0, addrPointer);
    tk(3'b011, 4);
    tk(3'b100, 5);
    @(posedge clock);
    calendarNow <= 56'h00fedcba987654;
    pin(~eventPinIn);
    chk("stamp", calendarNow, startStamp);
    chk("roll stamp", 5, rolloverStamp);
    chk("roll", 1'b1, statusRead[2]);
    pin(~eventPinIn);
    chk("log addr", 0, logAddr);
    chk("ptr", 2, addrPointer);
    chk("count", 1027, eventCount);
  endtask

  // reset for four cycles, then the scenarios in turn
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {secTick, minTick, hourTick, alarmFlag, mainAboveBackup, eventPinIn} = 6'h00;
    calendarNow = 56'h0123456789abcd;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    cyc(1);
    s_guard();
    s_edges();
    s_isel();
    s_log();
    s_wrap();
    closeOut();
  end
endmodule // test_emc_mission_control
